/* design/irq_map_consts.vh */
// Constants for the interrupt source to vector mapper
`ifndef IRQ_MAP_CONSTS_VH
`define IRQ_MAP_CONSTS_VH
`define IRQ_NUM_SOURCES   45
`define IRQ_NUM_VECTORS   34
`define IRQ_NUM_PRIO_WORDS 9
`define IRQ_WORD_BITS     32
`define IRQ_VEC_BITS      6
`define IRQ_SRC_BITS      6
`define IRQ_PRIO_BITS     3
`define IRQ_SUB_BITS      2
// Field positions inside a priority word, one slot of 8 bits per vector
`define IRQ_SLOT_BITS     8
`define IRQ_PRIO_LSB      2
`define IRQ_SUB_LSB       0
// Persistent sources (bit per request number, 45 bits)
`define IRQ_PERSIST_MASK  45'h1fff_f630_c660
// Default of the implemented source mask: every source present
`define IRQ_PRESENT_ALL   45'h1fff_ffff_ffff
`endif

/* design/irq_vector_mapper.v */
// Interrupt source to vector mapping, flag/enable/priority store and arbiter
`timescale 1ns/100ps
`include "irq_map_consts.vh"

// Ports in three groups:
//   source side: events, software set and clear, enables
//   priority side: one vector's fields written per strobe
//   core side: registered request, vector, source and levels
// Flags and enables are visible for status reads.
// Priority zero keeps a vector out of arbitration.
// Every source is treated as a level: a held source re-flags.

module irq_vector_mapper #(
  parameter [44:0] PRESENT = `IRQ_PRESENT_ALL
) (
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  input  wire [44:0] src_event_i,
  input  wire [44:0] flag_clear_i,
  input  wire [44:0] flag_set_i,
  input  wire [44:0] enable_i,
  input  wire [7:0]  prio_write_i,
  input  wire [5:0]  prio_vector_i,
  input  wire [2:0]  prio_value_i,
  input  wire [1:0]  sub_value_i,
  output reg  [44:0] flag_o,
  output reg  [44:0] enable_o,
  output wire        irq_req_o,
  output reg  [5:0]  irq_vector_o,
  output reg  [5:0]  irq_source_o,
  output reg  [2:0]  irq_prio_o,
  output reg  [1:0]  irq_sub_o
);

  // Vector for each request number; shared vectors are grouped items
  function [5:0] vec_of;
    input [5:0] n;
    begin
      case (n)
        // Core timer, software requests, first pin and timer
        6'h00:               vec_of = 6'h00;
        6'h01:               vec_of = 6'h01;
        6'h02:               vec_of = 6'h02;
        6'h03:               vec_of = 6'h03;
        6'h04:               vec_of = 6'h04;

        // Capture unit 1 group
        6'h05, 6'h06:        vec_of = 6'h05;
        6'h07:               vec_of = 6'h06;
        6'h08:               vec_of = 6'h07;
        6'h09:               vec_of = 6'h08;

        // Capture unit 2 group
        6'h0a, 6'h0b:        vec_of = 6'h09;
        6'h0c:               vec_of = 6'h0a;
        6'h0d:               vec_of = 6'h0b;
        6'h0e:               vec_of = 6'h0c;

        // Capture unit 3 group
        6'h0f, 6'h10:        vec_of = 6'h0d;
        6'h11:               vec_of = 6'h0e;
        6'h12:               vec_of = 6'h0f;
        6'h13:               vec_of = 6'h10;

        // Capture unit 4 group
        6'h14, 6'h15:        vec_of = 6'h11;
        6'h16:               vec_of = 6'h12;
        6'h17:               vec_of = 6'h13;
        6'h18:               vec_of = 6'h14;

        // Capture unit 5 group and converter done
        6'h19, 6'h1a:        vec_of = 6'h15;
        6'h1b:               vec_of = 6'h16;
        6'h1c:               vec_of = 6'h17;

        // Clock monitor, calendar, flash, comparators, serial bus
        6'h1d:               vec_of = 6'h18;
        6'h1e:               vec_of = 6'h19;
        6'h1f:               vec_of = 6'h1a;
        6'h20:               vec_of = 6'h1b;
        6'h21:               vec_of = 6'h1c;
        6'h22:               vec_of = 6'h1d;

        // Shared vectors of the serial ports and two-wire bus, then request 0x2c alone on vector 0x21
        6'h23, 6'h24, 6'h25: vec_of = 6'h1e;
        6'h26, 6'h27, 6'h28: vec_of = 6'h1f;
        6'h29, 6'h2a, 6'h2b: vec_of = 6'h20;
        6'h2c:               vec_of = 6'h21;
        default:             vec_of = 6'h00; // Unused numbers
      endcase
    end
  endfunction

  reg [2:0] prio_q [0:`IRQ_NUM_VECTORS-1];
  reg [1:0] sub_q  [0:`IRQ_NUM_VECTORS-1];

  // Next flag and enable per source; absent sources stay zero
  wire [44:0] flag_d;
  wire [44:0] enable_d;
  genvar g;
  generate
    for (g = 0; g < `IRQ_NUM_SOURCES; g = g + 1) begin : g_src
      if (PRESENT[g]) begin : g_on
        // Set wins over clear; a held source re-asserts its flag
        assign flag_d[g]   = src_event_i[g] | flag_set_i[g] |
                             (flag_o[g] & ~flag_clear_i[g]);
        assign enable_d[g] = enable_i[g];
      end else begin : g_off
        // Unimplemented source keeps no flag or enable
        assign flag_d[g]   = 1'b0;
        assign enable_d[g] = 1'b0;
      end
    end
  endgenerate

  // Flag and enable registers
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o   <= 45'h0;
      enable_o <= 45'h0;
    end else begin
      flag_o   <= flag_d;
      enable_o <= enable_d;
    end
  end

  // Priority field per vector; zero keeps the vector disabled
  integer v;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (v = 0; v < `IRQ_NUM_VECTORS; v = v + 1) begin
        prio_q[v] <= 3'h0;
      end
    end else if (prio_write_i[`IRQ_PRIO_LSB] && prio_vector_i < 6'h22) begin
      prio_q[prio_vector_i] <= prio_value_i;
    end
  end

  // Sub-priority field per vector
  integer s;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (s = 0; s < `IRQ_NUM_VECTORS; s = s + 1) begin
        sub_q[s] <= 2'h0;
      end
    end else if (prio_write_i[`IRQ_SUB_LSB] && prio_vector_i < 6'h22) begin
      sub_q[prio_vector_i] <= sub_value_i;
    end
  end

  // Sources that may compete: flagged, enabled and present
  wire [44:0] pend_w = flag_o & enable_o & PRESENT;

  // Arbiter: highest priority, then sub-priority, then lowest number
  reg        win_any;
  reg [5:0]  win_src;
  reg [5:0]  win_vec;
  reg [2:0]  win_pri;
  reg [1:0]  win_sub;
  reg [5:0]  cv;
  integer    n;
  always @* begin
    win_any = 1'b0;
    win_src = 6'h00;
    win_vec = 6'h00;
    win_pri = 3'h0;
    win_sub = 2'h0;
    cv      = 6'h00;
    for (n = 0; n < `IRQ_NUM_SOURCES; n = n + 1) begin
      cv = vec_of(n[5:0]);
      if (pend_w[n] && prio_q[cv] != 3'h0) begin
        // Strict greater keeps earlier (lower) number on ties
        if (!win_any || prio_q[cv] > win_pri ||
            (prio_q[cv] == win_pri && sub_q[cv] > win_sub)) begin
          win_any = 1'b1;
          win_src = n[5:0];
          win_vec = cv;
          win_pri = prio_q[cv];
          win_sub = sub_q[cv];
        end
      end
    end
  end

  // Registered request presented to the core
  reg req_q;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_q        <= 1'b0;
      irq_vector_o <= 6'h00;
      irq_source_o <= 6'h00;
      irq_prio_o   <= 3'h0;
      irq_sub_o    <= 2'h0;
    end else begin
      req_q        <= win_any;
      irq_vector_o <= win_vec;
      irq_source_o <= win_src;
      irq_prio_o   <= win_pri;
      irq_sub_o    <= win_sub;
    end
  end

  assign irq_req_o = req_q;

endmodule

/* dv/irq_map_asserts.sv */
// Checker for the interrupt vector mapper
`timescale 1ns/100ps
module irq_map_chk (
  input wire        core_clk_i,
  input wire        rst_n_i,
  input wire [44:0] src_event_i,
  input wire [44:0] flag_clear_i,
  input wire [44:0] flag_set_i,
  input wire [44:0] flag_o,
  input wire [44:0] enable_o,
  input wire        irq_req_o,
  input wire [5:0]  irq_vector_o,
  input wire [5:0]  irq_source_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_EVT: assert property (|src_event_i |=> (flag_o & $past(src_event_i)) == $past(src_event_i))
    else $error("flag not set by event");
  AST_CLR: assert property (flag_clear_i[0] && !src_event_i[0] && !flag_set_i[0] |=> !flag_o[0])
    else $error("flag not cleared");
  AST_REQ: assert property (irq_req_o |-> $past(|(flag_o & enable_o)))
    else $error("request without pending source");
  AST_V0: assert property (irq_req_o && irq_source_o == 6'h00 |-> irq_vector_o == 6'h00)
    else $error("bad vector");
  AST_CAP: assert property (irq_req_o && irq_source_o inside {6'h05, 6'h06} |-> irq_vector_o == 6'h05)
    else $error("bad vector");
  AST_AD: assert property (irq_req_o && irq_source_o == 6'h1c |-> irq_vector_o == 6'h17)
    else $error("bad vector");
  AST_SPI: assert property (irq_req_o && irq_source_o inside {[6'h23:6'h25]} |-> irq_vector_o == 6'h1e)
    else $error("bad vector");
  AST_CN: assert property (irq_req_o && irq_source_o == 6'h2c |-> irq_vector_o == 6'h21)
    else $error("bad vector");
endmodule
bind irq_vector_mapper irq_map_chk chk_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .src_event_i(src_event_i), .flag_clear_i(flag_clear_i), .flag_set_i(flag_set_i),
  .flag_o(flag_o), .enable_o(enable_o), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
  .irq_source_o(irq_source_o));

/* dv/src_model.sv */
// Source model: one-cycle request pulse or held level
`timescale 1ns/100ps
module src_model (
  input  wire        core_clk_i,
  input  wire        fire_i,
  input  wire        hold_i,
  input  wire [5:0]  num_i,
  output reg  [44:0] ev_o
);
  initial ev_o = 45'h0;
  // Pulse or level on the selected request
  always @(posedge core_clk_i) begin
    ev_o <= (fire_i || hold_i) ? (45'h1 << num_i) : 45'h0;
  end
endmodule

/* dv/tb_irq_vector_mapper.sv */
// Self-checking bench for the interrupt vector mapper
`timescale 1ns/100ps
module tb_irq_vector_mapper;
  reg         core_clk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg         fire = 1'b0;
  reg         hold = 1'b0;
  reg  [5:0]  num = 6'h00;
  reg  [5:0]  pv = 6'h00;
  reg  [2:0]  pval = 3'h0;
  reg  [7:0]  pw = 8'h00;
  reg  [44:0] clr = 45'h0;
  reg  [44:0] xev = 45'h0;
  reg  [44:0] en = 45'h0;
  reg  [16:0] exp_q[$];
  reg  [44:0] fset = 45'h0;
  reg  [1:0]  sval = 2'h0;
  wire [44:0] en_o;
  wire [1:0]  sub;
  reg         req_q = 1'b0;
  wire [44:0] ev, flag;
  wire [5:0]  vec, src;
  wire [2:0]  prio;
  wire        req;
  integer     failures = 0;
  integer     n_checks = 0;
  integer     seed = 32'h5b9d;
  integer     cyc = 0;
  integer     k;
  always #10 core_clk_i = ~core_clk_i;
  src_model pm (.core_clk_i(core_clk_i), .fire_i(fire), .hold_i(hold), .num_i(num), .ev_o(ev));
  irq_vector_mapper uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .src_event_i(ev | xev),
    .flag_clear_i(clr), .flag_set_i(fset), .enable_i(en), .prio_write_i(pw),
    .prio_vector_i(pv), .prio_value_i(pval), .sub_value_i(sval), .flag_o(flag),
    .enable_o(en_o), .irq_req_o(req), .irq_vector_o(vec), .irq_source_o(src),
    .irq_prio_o(prio), .irq_sub_o(sub));
  task chk(input [44:0] s, input [44:0] e); begin
    n_checks = n_checks + 1;
    if (s !== e) begin
      failures = failures + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  end endtask
  task final_report; begin
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end endtask
  task tick(input integer n); begin
    repeat (n) @(posedge core_clk_i);
    #1;
  end endtask
  function [5:0] vmap(input integer r); begin
    if (r < 5) vmap = r;
    else if (r < 28) vmap = ((r - 5) % 5 < 2) ? 5 + 4 * ((r - 5) / 5) : 4 + r - 5 - (r - 5) / 5;
    else if (r < 35) vmap = r - 5;
    else vmap = 30 + (r - 35) / 3;
  end endfunction
  // Compare the oldest note on each new request; cycle limit
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      failures = failures + 1;
      final_report;
    end
    req_q <= req;
    if (req === 1'b1 && req_q !== 1'b1) chk({vec, src, prio, sub}, exp_q.pop_front());
  end
  // Every source alone, then a tie and a held source
  initial begin
    tick(10);
    rst_n_i = 1'b1;
    for (k = 0; k < 45; k = k + 1) begin
      pval = 3'h1 + $unsigned($random(seed)) % 7;
      sval = $random(seed);
      pv = vmap(k);
      pw = 8'h05;
      en = 45'h1 << k;
      num = k;
      tick(1);
      chk(en_o, en);
      pw = 8'h00;
      fire = 1'b1;
      exp_q.push_back({vmap(k), k[5:0], pval, sval});
      tick(1);
      fire = 1'b0;
      tick(3);
      clr = en;
      tick(1);
      clr = 45'h0;
      en = 45'h0;
      tick(2);
    end
    pv = 6'h01;
    pval = 3'h4;
    sval = 2'h1;
    pw = 8'h05;
    tick(1);
    pv = 6'h02;
    sval = 2'h3;
    tick(1);
    pw = 8'h00;
    en = 45'h6;
    fset = 45'h6;
    tick(1);
    fset = 45'h0;
    exp_q.push_back({6'h02, 6'h02, 3'h4, 2'h3});
    tick(3);
    clr = 45'h6;
    en = 45'h0;
    tick(1);
    clr = 45'h0;
    tick(2);
    pv = 6'h05;
    pval = 3'h3;
    sval = 2'h1;
    pw = 8'h05;
    en = 45'h60;
    xev = 45'h60;
    tick(1);
    pw = 8'h00;
    xev = 45'h0;
    exp_q.push_back({6'h05, 6'h05, 3'h3, 2'h1});
    tick(4);
    hold = 1'b1;
    num = 6'h1c;
    tick(2);
    clr = ~45'h0;
    tick(2);
    chk(flag[28], 1'b1);
    hold = 1'b0;
    tick(2);
    final_report;
  end
endmodule
